/* hw/tbx_exec.sv */
// Contract
// - A table read puts the program memory byte at the pointer into the byte latch and leaves flags alone.
// - The table pointer is 21 bits wide and addresses single bytes of a two megabyte space.
// - Pointer bit zero picks the low byte of a program word when clear and the high byte when set.
// - Table read mode 0 keeps the pointer, 1 increments after, 2 decrements after, 3 increments before.
// - A table write copies the byte latch into the holding register chosen by the low three pointer bits.
// - A table write uses the same four pointer modes as a table read.
// - A table write only loads holding registers; flash programming uses them later.
// - Test-and-skip on a zero register discards the fetched next instruction and spends two cycles.
// - If the skipped instruction has two words the test-and-skip spends three cycles.
// - Operand bit a clear selects the access bank and set selects the bank select register.
// - With a clear and the extended set on, offsets up to 95 are indexed from the frame pointer.
// - XOR literal combines the working register with an 8-bit immediate, writes it back and sets N and Z.
// - XOR with register stores to the working register when d is 0 and to the file register when d is 1.
// - XOR with register takes one cycle and changes only the N and Z flags.
`timescale 1ns/1ps
`default_nettype none
`include "tbx_cfg.svh"

module tbx_exec import tbx_pkg::*; #(
  parameter int PTR_W  = `TBX_PTR_W,
  parameter int HOLD_N = `TBX_HOLD_N
) (
  // Clock and reset.
  input  wire logic                   clk_in,
  input  wire logic                   rst_in,
  // Instruction stream from the fetch logic.
  input  wire logic [15:0]            instr_in,
  input  wire logic                   instr_valid_in,
  input  wire logic                   next_two_word_in,
  input  wire logic [11:0]            fsr2_in,
  output logic                        instr_ready_out,
  output logic                        skip_out,
  // Program memory read port.
  output logic                        pm_rd_out,
  output logic      [PTR_W-1:0]       pm_addr_out,
  input  wire logic [15:0]            pm_word_in,
  // Data register file port.
  output tbx_rf_req_t                 rf_out,
  input  wire logic [7:0]             rf_rdata_in,
  // Status and visible state.
  output tbx_flags_t                  flags_out,
  output logic      [7:0]             wreg_out,
  output logic      [7:0]             latch_out,
  output logic      [HOLD_N*8-1:0]    hold_bytes_out,
  // APB register bus.
  input  wire logic                   psel_in,
  input  wire logic                   penable_in,
  input  wire logic                   pwrite_in,
  input  wire logic [`TBX_ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]            pwdata_in,
  output logic      [31:0]            prdata_out,
  output logic                        pready_out,
  output logic                        pslverr_out
);

  localparam int HIW = $clog2(HOLD_N);

  if (HOLD_N < 2 || HOLD_N > 8 || HOLD_N != (1 << HIW) || PTR_W <= HIW || PTR_W > 32) begin : g_bad_param
    $error("HOLD_N must be a power of two up to 8 and PTR_W must fit the bus");
  end

  tbx_state_t       state;
  tbx_state_t       next_state;
  logic [1:0]       q;
  logic [15:0]      ir;
  logic             act;
  logic [7:0]       opnd;
  logic [PTR_W-1:0] table_pointer;
  logic [7:0]       table_byte_latch;
  logic [3:0]       bank_select_register;
  logic             ext_en;
  logic [7:0]       hold [HOLD_N];

  logic             is_tbl;
  logic             is_tblwr;
  logic             is_xor_literal_op;
  logic             is_xor_register_op;
  logic             is_tst;
  logic             supported;
  logic [1:0]       pointer_mode_field;
  logic [7:0]       f_off;
  logic [11:0]      f_addr;
  logic [7:0]       xor_res;
  logic             wb;
  logic             tbl_end;
  logic             skip_hit;
  logic [PTR_W-1:0] acc_addr;
  logic [PTR_W-1:0] ptr_new;
  logic [7:0]       wr_sel;
  logic [31:0]      sw_data;
  logic [7:0][31:0] words;

  // Opcode decode of the held instruction word; supported decodes the incoming instr_in word.
  assign pointer_mode_field = ir[1:0];
  assign is_tbl    = (ir[15:4] == `TBX_OP_TBL_HI) && ir[3];
  assign is_tblwr  = is_tbl && (ir[3:2] == `TBX_OP_PROGRAM_MEM_WRITE_OP);
  assign is_xor_literal_op  = (ir[15:8] == `TBX_OP_XOR_LITERAL_OP);
  assign is_xor_register_op  = (ir[15:10] == `TBX_OP_XOR_REGISTER_OP);
  assign is_tst    = (ir[15:9] == `TBX_OP_TEST_ZERO_SKIP_OP);
  assign supported = ((instr_in[15:4] == `TBX_OP_TBL_HI) && instr_in[3]) || (instr_in[15:8] == `TBX_OP_XOR_LITERAL_OP)
                     || (instr_in[15:10] == `TBX_OP_XOR_REGISTER_OP) || (instr_in[15:9] == `TBX_OP_TEST_ZERO_SKIP_OP);

  // Operand address: banked, indexed or access bank.
  // bank selection
  assign f_off  = ir[7:0];
  assign f_addr = ir[`TBX_A_BIT] ? {bank_select_register, f_off}
                : (ext_en && (f_off <= `TBX_ACC_LIMIT)) ? (fsr2_in + {4'h0, f_off})
                : (f_off <= `TBX_ACC_LIMIT) ? {4'h0, f_off} : {`TBX_ACC_HI_BANK, f_off};

  // ALU result and phase strobes.
  // xor datapath
  assign xor_res  = wreg_out ^ (is_xor_literal_op ? ir[7:0] : opnd);
  assign wb       = act && (q == `TBX_Q_WRITE);
  assign tbl_end  = (state == TBX_S_TBL) && (q == `TBX_Q_WRITE);
  assign skip_hit = wb && is_tst && (opnd == 8'h00);

  tbx_ptr_step #(
    .PTR_W   (PTR_W)
  ) u_ptr (
    .ptr_in  (table_pointer),
    .mode_in (pointer_mode_field),
    .acc_out (acc_addr),
    .nxt_out (ptr_new)
  );

  // Register view for software reads.
  assign words[0] = {31'h0000_0000, ext_en};
  assign words[1] = 32'(table_pointer);
  assign words[2] = {24'h00_0000, table_byte_latch};
  assign words[3] = {28'h000_0000, bank_select_register};
  assign words[4] = {24'h00_0000, wreg_out};
  assign words[5] = {29'h0000_0000, state != TBX_S_RUN, flags_out.z, flags_out.n};
  assign words[6] = {hold[3 % HOLD_N], hold[2 % HOLD_N], hold[1], hold[0]};
  assign words[7] = {hold[7 % HOLD_N], hold[6 % HOLD_N], hold[5 % HOLD_N], hold[4 % HOLD_N]};

  tbx_apb_slave #(
    .NREG        (8)
  ) u_apb (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .psel_in     (psel_in),
    .penable_in  (penable_in),
    .pwrite_in   (pwrite_in),
    .paddr_in    (paddr_in),
    .pwdata_in   (pwdata_in),
    .prdata_out  (prdata_out),
    .pready_out  (pready_out),
    .pslverr_out (pslverr_out),
    .words_in    (words),
    .wr_sel_out  (wr_sel),
    .wdata_out   (sw_data)
  );

  // Sequencing after the write quarter.
  // cycle counts
  always_comb begin
    next_state = state;
    case (state)
      TBX_S_RUN: begin
        if (wb && is_tbl) begin
          next_state = TBX_S_TBL;
        end else if (skip_hit) begin
          next_state = next_two_word_in ? TBX_S_NOP2 : TBX_S_NOP1;
        end
      end
      TBX_S_TBL:  next_state = TBX_S_RUN;
      TBX_S_NOP2: next_state = TBX_S_NOP1;
      TBX_S_NOP1: next_state = TBX_S_RUN;
      default:    next_state = TBX_S_RUN;
    endcase
  end

  // Quarter counter, state and fetch handshake.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      q               <= `TBX_Q_DECODE;
      state           <= TBX_S_RUN;
      instr_ready_out <= 1'b1;
      skip_out        <= 1'b0;
    end else begin
      q        <= q + 2'h1;
      skip_out <= skip_hit;
      if (q == `TBX_Q_WRITE) begin
        state           <= next_state;
        instr_ready_out <= (next_state == TBX_S_RUN);
      end
    end
  end

  // Instruction capture in the decode quarter.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ir  <= 16'h0000;
      act <= 1'b0;
    end else if (q == `TBX_Q_DECODE) begin
      act <= (state == TBX_S_RUN) && instr_valid_in && supported;
      if (state == TBX_S_RUN) begin
        ir <= instr_in;
      end
    end
  end

  // Operand reads, then register file write-back in the next decode quarter.
  // destination select
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rf_out      <= '0;
      pm_rd_out   <= 1'b0;
      pm_addr_out <= '0;
    end else begin
      case (q)
        `TBX_Q_DECODE: rf_out.wr <= 1'b0;
        `TBX_Q_READ: begin
          rf_out.rd   <= act && (is_xor_register_op || is_tst);
          rf_out.addr <= f_addr;
          pm_rd_out   <= (state == TBX_S_TBL) && !is_tblwr;
          pm_addr_out <= acc_addr;
        end
        `TBX_Q_PROCESS: begin
          rf_out.rd <= 1'b0;
          pm_rd_out <= 1'b0;
        end
        default: begin
          rf_out.wr    <= wb && is_xor_register_op && ir[`TBX_D_BIT];
          rf_out.wdata <= xor_res;
        end
      endcase
    end
  end

  // Operand capture; the pointer's bit zero picks the byte of a program word.
  // byte select
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      opnd <= 8'h00;
    end else if (q == `TBX_Q_PROCESS) begin
      if (rf_out.rd) begin
        opnd <= rf_rdata_in;
      end else if (pm_rd_out) begin
        opnd <= pm_addr_out[0] ? pm_word_in[15:8] : pm_word_in[7:0];
      end
    end
  end

  // Working register and flags; core updates win over software writes.
  // result and flags
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wreg_out  <= `TBX_RST_BYTE;
      flags_out <= '0;
    end else begin
      flags_out.we <= wb && (is_xor_literal_op || is_xor_register_op);
      if (wb && (is_xor_literal_op || is_xor_register_op)) begin
        flags_out.n <= xor_res[7];
        flags_out.z <= (xor_res == 8'h00);
      end
      if (wb && (is_xor_literal_op || (is_xor_register_op && !ir[`TBX_D_BIT]))) begin
        wreg_out <= xor_res;
      end else if (wr_sel[4]) begin
        wreg_out <= sw_data[7:0];
      end
    end
  end

  // Table pointer, byte latch and software controls.
  // table state update
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      table_pointer        <= PTR_W'(`TBX_RST_PTR);
      table_byte_latch     <= `TBX_RST_BYTE;
      bank_select_register <= `TBX_RST_BANK;
      ext_en               <= `TBX_RST_EXT;
    end else begin
      if (tbl_end) begin
        table_pointer <= ptr_new;
      end else if (wr_sel[1]) begin
        table_pointer <= sw_data[PTR_W-1:0];
      end
      if (tbl_end && !is_tblwr) begin
        table_byte_latch <= opnd;
      end else if (wr_sel[2]) begin
        table_byte_latch <= sw_data[7:0];
      end
      if (wr_sel[3]) begin
        bank_select_register <= sw_data[3:0];
      end
      if (wr_sel[0]) begin
        ext_en <= sw_data[`TBX_CTRL_EXT_BIT];
      end
    end
  end

  assign latch_out = table_byte_latch;

  // Holding registers, one byte each.
  // holding load
  for (genvar i = 0; i < HOLD_N; i++) begin : g_hold
    always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
        hold[i] <= `TBX_RST_BYTE;
      end else if (tbl_end && is_tblwr && (acc_addr[HIW-1:0] == HIW'(i))) begin
        hold[i] <= table_byte_latch;
      end
    end
    assign hold_bytes_out[i*8 +: 8] = hold[i];
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_tbl_start;
    (state == TBX_S_RUN) && wb && is_tbl;
  endsequence

  sequence s_tbl_second;
    (state == TBX_S_TBL) [*4];
  endsequence

  AST_TBL_TWO_CYCLES: assert property (s_tbl_start |=> s_tbl_second ##1 (state == TBX_S_RUN))
    else $error("table access did not take exactly two instruction cycles");

  AST_PROGRAM_MEM_READ_OP_LATCH: assert property (tbl_end && !is_tblwr |=> table_byte_latch == $past(opnd) && !flags_out.we)
    else $error("table read did not load the latch or touched flags");

  AST_BYTE_SELECT: assert property (q == `TBX_Q_PROCESS && pm_rd_out
    |=> opnd == ($past(pm_addr_out[0]) ? $past(pm_word_in[15:8]) : $past(pm_word_in[7:0])))
    else $error("wrong program word byte selected");

  AST_PTR_MODES: assert property (tbl_end |=> table_pointer == (($past(pointer_mode_field) == 2'h0) ? $past(table_pointer)
    : ($past(pointer_mode_field) == 2'h2) ? $past(table_pointer) - PTR_W'(1) : $past(table_pointer) + PTR_W'(1)))
    else $error("table pointer update does not match mode");

  AST_PTR_WRAP: assert property (tbl_end && pointer_mode_field[0] && (&table_pointer) |=> table_pointer == '0)
    else $error("table pointer did not wrap at its width");

  AST_HOLD_LOAD: assert property (tbl_end && is_tblwr
    |=> hold[$past(acc_addr[HIW-1:0])] == $past(table_byte_latch) && table_byte_latch == $past(table_byte_latch))
    else $error("holding register not loaded from latch");

  sequence s_skip_one;
    (!instr_ready_out) [*4] ##1 instr_ready_out;
  endsequence

  AST_SKIP_TWO: assert property (skip_hit && !next_two_word_in |=> s_skip_one)
    else $error("single word skip did not last one extra cycle");

  AST_SKIP_THREE: assert property (skip_hit && next_two_word_in |=> (!instr_ready_out) [*8] ##1 instr_ready_out)
    else $error("two word skip did not last two extra cycles");

  AST_BANKED: assert property (rf_out.rd && ir[`TBX_A_BIT] |-> rf_out.addr[11:8] == bank_select_register)
    else $error("banked operand ignores bank select register");

  AST_INDEXED: assert property (q == `TBX_Q_READ && act && is_xor_register_op && !ir[`TBX_A_BIT] && ext_en && ir[7:0] <= 8'h5F
    |=> rf_out.addr == $past(fsr2_in) + {4'h0, $past(ir[7:0])})
    else $error("indexed literal offset address wrong");

  AST_XOR_LITERAL_OP: assert property (wb && is_xor_literal_op |=> wreg_out == ($past(wreg_out) ^ $past(ir[7:0])) && flags_out.we
    && flags_out.z == (wreg_out == 8'h00) && flags_out.n == wreg_out[7])
    else $error("xor literal result or flags wrong");

  AST_XOR_REGISTER_OP_DEST: assert property (wb && is_xor_register_op && ir[`TBX_D_BIT]
    |=> rf_out.wr && rf_out.wdata == ($past(wreg_out) ^ $past(opnd)) && wreg_out == $past(wreg_out))
    else $error("xor register result sent to wrong destination");

  AST_XOR_REGISTER_OP_FLAGS: assert property (wb && is_xor_register_op |=> flags_out.n == rf_out.wdata[7]
    && flags_out.z == (rf_out.wdata == 8'h00) && state == TBX_S_RUN)
    else $error("xor register flags wrong or extra cycle taken");

endmodule

`default_nettype wire

/* hw/tbx_cfg.svh */
`ifndef TBX_CFG_SVH
`define TBX_CFG_SVH

// Widths and sizes.
`define TBX_PTR_W        21
`define TBX_HOLD_N       8
`define TBX_ADDR_W       8

// Register offsets (byte addresses).
`define TBX_OFF_CTRL     8'h00
`define TBX_OFF_PTR      8'h04
`define TBX_OFF_LATCH    8'h08
`define TBX_OFF_BANK     8'h0C
`define TBX_OFF_WREG     8'h10
`define TBX_OFF_STAT     8'h14
`define TBX_OFF_HOLDLO   8'h18
`define TBX_OFF_HOLDHI   8'h1C

// Field positions.
`define TBX_CTRL_EXT_BIT 0
`define TBX_STAT_N_BIT   0
`define TBX_STAT_Z_BIT   1
`define TBX_STAT_BSY_BIT 2
`define TBX_A_BIT        8
`define TBX_D_BIT        9

// Reset values.
`define TBX_RST_PTR      21'h00_0000
`define TBX_RST_BYTE     8'h00
`define TBX_RST_BANK     4'h0
`define TBX_RST_EXT      1'b0

// Opcode encodings.
`define TBX_OP_TBL_HI    12'h000
`define TBX_OP_PROGRAM_MEM_READ_OP     2'h2
`define TBX_OP_PROGRAM_MEM_WRITE_OP     2'h3
`define TBX_OP_XOR_LITERAL_OP     8'h0A
`define TBX_OP_XOR_REGISTER_OP     6'h06
`define TBX_OP_TEST_ZERO_SKIP_OP    7'h33

// Operand address map.
`define TBX_ACC_LIMIT    8'h5F
`define TBX_ACC_HI_BANK  4'hF

// Timing: clock ticks per instruction cycle and the quarter index of each phase.
`define TBX_QUARTERS     4
`define TBX_Q_DECODE     2'h0
`define TBX_Q_READ       2'h1
`define TBX_Q_PROCESS    2'h2
`define TBX_Q_WRITE      2'h3

`endif

/* hw/tbx_pkg.sv */
package tbx_pkg;

  // Execution states, one bit apart from RUN to NOP2 and from NOP2 to NOP1.
  typedef enum logic [1:0] {
    TBX_S_RUN  = 2'h0,
    TBX_S_TBL  = 2'h1,
    TBX_S_NOP1 = 2'h3,
    TBX_S_NOP2 = 2'h2
  } tbx_state_t;

  // Request towards the data register file.
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } tbx_rf_req_t;

  // Flag update towards the status register.
  typedef struct packed {
    logic we;
    logic n;
    logic z;
  } tbx_flags_t;

endpackage

/* hw/tbx_ptr_step.sv */
`timescale 1ns/1ps
`default_nettype none

module tbx_ptr_step #(
  parameter int PTR_W = 21
) (
  // Current pointer and mode.
  input  wire logic [PTR_W-1:0] ptr_in,
  input  wire logic [1:0]       mode_in,
  // Access address and updated pointer.
  output logic      [PTR_W-1:0] acc_out,
  output logic      [PTR_W-1:0] nxt_out
);

  logic [PTR_W-1:0] inc;
  logic [PTR_W-1:0] dec;

  // Both neighbours wrap inside the pointer width.
  assign inc = ptr_in + PTR_W'(1);
  assign dec = ptr_in - PTR_W'(1);

  // Mode 3 uses the incremented pointer for the access itself.
  assign acc_out = (mode_in == 2'h3) ? inc : ptr_in;
  assign nxt_out = (mode_in == 2'h0) ? ptr_in : (mode_in == 2'h2) ? dec : inc;

endmodule

`default_nettype wire

/* hw/tbx_apb_slave.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tbx_cfg.svh"

module tbx_apb_slave #(
  parameter int NREG = 8
) (
  // Clock and reset.
  input  wire logic                   clk_in,
  input  wire logic                   rst_in,
  // APB slave side.
  input  wire logic                   psel_in,
  input  wire logic                   penable_in,
  input  wire logic                   pwrite_in,
  input  wire logic [`TBX_ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]            pwdata_in,
  output logic      [31:0]            prdata_out,
  output logic                        pready_out,
  output logic                        pslverr_out,
  // Register view and write strobes.
  input  wire logic [NREG-1:0][31:0]  words_in,
  output logic      [NREG-1:0]        wr_sel_out,
  output logic      [31:0]            wdata_out
);

  localparam int IW = $clog2(NREG);

  if (NREG < 2 || NREG != (1 << IW)) begin : g_bad_nreg
    $error("NREG must be a power of two of at least two");
  end

  logic          setup;
  logic          mapped;
  logic [IW-1:0] idx;
  logic          wr_fire;

  // Address decode: aligned words inside the window only.
  assign setup   = psel_in && !penable_in;
  assign idx     = paddr_in[IW+1:2];
  assign mapped  = (paddr_in[1:0] == 2'h0) && ((paddr_in >> (IW + 2)) == '0);
  assign wr_fire = psel_in && penable_in && pready_out && pwrite_in && mapped;

  // One-hot write strobe at the completing access edge.
  for (genvar i = 0; i < NREG; i++) begin : g_sel
    assign wr_sel_out[i] = wr_fire && (idx == IW'(i));
  end
  assign wdata_out = pwdata_in;

  // Ready, error and read data are prepared in the setup cycle.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      pready_out  <= setup;
      pslverr_out <= setup && !mapped;
      if (setup) begin
        prdata_out <= (mapped && !pwrite_in) ? words_in[idx] : 32'h0000_0000;
      end
    end
  end

endmodule

`default_nettype wire

/* test/tbx_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none

module tbx_mem_model import tbx_pkg::*; (
  // Clock.
  input  wire logic        clk_in,
  // Program memory read port.
  input  wire logic        pm_rd_in,
  input  wire logic [20:0] pm_addr_in,
  output logic      [15:0] pm_word_out,
  // Data register file port.
  input  wire tbx_rf_req_t rf_in,
  output logic      [7:0]  rf_rdata_out
);
  logic [7:0]  rf [4096];
  logic [15:0] word;

  // Program memory holds a fixed pattern of the byte address.
  function automatic logic [7:0] pm_byte(input logic [20:0] b);
    return b[8:1] ^ b[16:9] ^ (b[0] ? 8'hC3 : 8'h5A);
  endfunction

  // Outside a read strobe the buses show inverted data, so stale values cannot pass.
  assign word         = {pm_byte({pm_addr_in[20:1], 1'b1}), pm_byte({pm_addr_in[20:1], 1'b0})};
  assign pm_word_out  = pm_rd_in ? word : ~word;
  assign rf_rdata_out = rf_in.rd ? rf[rf_in.addr] : ~rf[rf_in.addr];

  // File registers start from a known pattern and take core writes.
  initial begin
    for (int i = 0; i < 4096; i++) begin
      rf[i] = i[7:0];
    end
  end
  always @(posedge clk_in) begin
    if (rf_in.wr) begin
      rf[rf_in.addr] <= rf_in.wdata;
    end
  end
endmodule

`default_nettype wire

/* test/table_access_test_xor_exec_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tbx_cfg.svh"

module table_access_test_xor_exec_tb_top import tbx_pkg::*;;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [15:0] instr = 16'h0000;
  logic        valid = 1'b0, two_word = 1'b0, ready, skip, pm_rd;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [7:0]  paddr = 8'h00, rf_rdata, wreg, latch;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [20:0] pm_addr;
  logic [15:0] pm_word;
  logic [63:0] hold;
  tbx_rf_req_t rf;
  tbx_flags_t  flags;
  logic [1:0]  qc = 2'h0;
  int          cyc = 0, skips = 0, mismatches = 0, check_count = 0, t0, t1, n;

  tbx_exec dut (.clk_in(clk_in), .rst_in(rst_in), .instr_in(instr), .instr_valid_in(valid),
    .next_two_word_in(two_word), .fsr2_in(12'h100), .instr_ready_out(ready), .skip_out(skip),
    .pm_rd_out(pm_rd), .pm_addr_out(pm_addr), .pm_word_in(pm_word), .rf_out(rf), .rf_rdata_in(rf_rdata),
    .flags_out(flags), .wreg_out(wreg), .latch_out(latch), .hold_bytes_out(hold), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr));

  tbx_mem_model mem (.clk_in(clk_in), .pm_rd_in(pm_rd), .pm_addr_in(pm_addr), .pm_word_out(pm_word),
    .rf_in(rf), .rf_rdata_out(rf_rdata));

  // Clock generator.
  initial forever #12.5 clk_in = ~clk_in;

  // Quarter tracker, cycle count and skip pulse count.
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    qc <= rst_in ? 2'h0 : qc + 2'h1;
    if (skip === 1'b1) skips <= skips + 1;
  end

  // Compares one value and reports a mismatch.
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; holds the request until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Offers a word from quarter 3 and holds it until a decode edge with ready high.
  task automatic issue(input logic [15:0] w, output int t);
    do @(posedge clk_in); while (qc !== 2'h3);
    instr <= w;
    valid <= 1'b1;
    do @(posedge clk_in); while (!(qc === 2'h0 && ready === 1'b1));
    valid <= 1'b0;
    t = cyc;
  endtask

  // Exclusive OR with a literal, then the working register and flags.
  task automatic xl(input logic [7:0] k, input logic [7:0] w, input logic nn, input logic z);
    issue({8'h0A, k}, t0);
    repeat (5) @(posedge clk_in);
    chk("xor_literal_op_w", wreg, w);
    chk("xor_literal_op_nz", {flags.n, flags.z}, {nn, z});
  endtask

  // Exclusive OR with a file register for one operand case.
  task automatic xw(input logic [7:0] f, input logic a, d, input logic [3:0] bk, input logic ext,
                    input logic [11:0] ad);
    apb(1'b1, `TBX_OFF_WREG, 32'h0000_00B5);
    apb(1'b1, `TBX_OFF_BANK, {28'h0, bk});
    apb(1'b1, `TBX_OFF_CTRL, {31'h0, ext});
    mem.rf[ad] = 8'hAF;
    issue({6'h06, d, a, f}, t0);
    repeat (6) @(posedge clk_in);
    chk("xor_register_op_dest", d ? mem.rf[ad] : wreg, 8'h1A);
    chk("xor_register_op_other", d ? wreg : mem.rf[ad], d ? 8'hB5 : 8'hAF);
    chk("xor_register_op_nz", {flags.n, flags.z}, 2'b00);
  endtask

  // Table read or write with one pointer mode, then pointer, latch or holding byte.
  task automatic tbl(input logic w, input logic [1:0] m, input logic [20:0] p);
    logic [20:0] acc, nxt;
    acc = (m == 2'h3) ? p + 21'h1 : p;
    nxt = (m == 2'h0) ? p : (m == 2'h2) ? p - 21'h1 : p + 21'h1;
    apb(1'b1, `TBX_OFF_LATCH, {24'h0, p[7:0] ^ 8'h96});
    apb(1'b1, `TBX_OFF_PTR, {11'h0, p});
    issue({12'h000, 1'b1, w, m}, t0);
    issue(16'h0A00, t1);
    chk("tbl_cycles", 32'(t1 - t0), 32'd8);
    repeat (4) @(posedge clk_in);
    if (w) chk("hold_byte", hold[{acc[2:0], 3'h0} +: 8], p[7:0] ^ 8'h96);
    else chk("latch", latch, mem.pm_byte(acc));
    apb(1'b0, `TBX_OFF_PTR, 32'h0000_0000);
    chk("pointer", rd, {11'h0, nxt});
  endtask

  // Prints the verdict and ends the run.
  task automatic conclude();
    if (mismatches == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog against a hang.
  initial begin
    repeat (20000) @(posedge clk_in);
    mismatches++;
    conclude();
  end

  // Main sequence.
  initial begin
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    apb(1'b0, `TBX_OFF_PTR, 32'h0000_0000);
    chk("pointer_reset", rd, 32'h0000_0000);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk("unmapped_err", {31'h0, err}, 32'h0000_0001);
    apb(1'b1, `TBX_OFF_WREG, 32'h0000_00B5);
    xl(8'hAF, 8'h1A, 1'b0, 1'b0);
    xl(8'h1A, 8'h00, 1'b0, 1'b1);
    xl(8'h93, 8'h93, 1'b1, 1'b0);
    issue(16'h0AFF, t0);
    issue(16'h0A6C, t1);
    repeat (5) @(posedge clk_in);
    chk("xor_literal_op_gap", 32'(t1 - t0), 32'd4);
    chk("xor_literal_op_pair", wreg, 8'h00);
    xw(8'h20, 1'b0, 1'b1, 4'h0, 1'b0, 12'h020);
    xw(8'h80, 1'b0, 1'b1, 4'h0, 1'b0, 12'hF80);
    xw(8'h10, 1'b1, 1'b1, 4'h3, 1'b0, 12'h310);
    xw(8'h05, 1'b0, 1'b1, 4'h0, 1'b1, 12'h105);
    xw(8'h60, 1'b0, 1'b0, 4'h0, 1'b1, 12'hF60);
    for (int m = 0; m < 4; m++) begin
      tbl(1'b0, m[1:0], 21'h0_A356);
      tbl(1'b1, m[1:0], 21'h1_389A);
    end
    tbl(1'b0, 2'h3, 21'h1F_FFFF);
    tbl(1'b0, 2'h1, 21'h1F_FFFF);
    tbl(1'b1, 2'h2, 21'h0_0000);
    apb(1'b1, `TBX_OFF_CTRL, 32'h0000_0000);
    for (int i = 0; i < 3; i++) begin
      mem.rf[12'h020] = (i == 2) ? 8'h01 : 8'h00;
      two_word <= (i == 1);
      n = skips;
      issue(16'h6620, t0);
      issue(16'h0A00, t1);
      chk("skip_gap", 32'(t1 - t0), (i == 0) ? 32'd8 : (i == 1) ? 32'd12 : 32'd4);
      chk("skip_pulses", 32'(skips - n), (i == 2) ? 32'd0 : 32'd1);
    end
    conclude();
  end
endmodule

`default_nettype wire
